//--- logic/fp_state_pkg.sv
package fp_state_pkg;

    // ==========================================================
    // Coprocessor numbers, flags system location and access field encodings
    localparam logic [3:0] CP_NUM_PRIMARY   = 4'hA;
    localparam logic [3:0] CP_NUM_SECONDARY = 4'hB;
    localparam logic [3:0] FLAGS_LOC        = 4'h1;
    localparam logic [1:0] ACC_DENIED       = 2'h0;
    localparam logic [1:0] ACC_PRIV         = 2'h1;
    localparam logic [1:0] ACC_FULL         = 2'h3;
    localparam logic [3:0] ACC_RESET        = 4'h0;

    // ==========================================================
    // Status and control field positions
    localparam int POS_FLAGS = 28;
    localparam int POS_AHP   = 26;
    localparam int POS_DN    = 25;
    localparam int POS_FZ    = 24;
    localparam int POS_RMODE = 22;
    localparam int POS_IOC   = 0;
    localparam int POS_DZC   = 1;
    localparam int POS_OFC   = 2;
    localparam int POS_UFC   = 3;
    localparam int POS_IXC   = 4;
    localparam int POS_IDC   = 7;
    localparam logic [31:0] STATUS_WR_MASK = 32'hF7C0_009F;
    localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
    localparam logic [1:0]  RMODE_NEAREST  = 2'h0;

    // ==========================================================
    // Feature identification values
    localparam logic [31:0] FEATURE_ID_A = 32'h0000_0001;
    localparam logic [31:0] FEATURE_ID_B = 32'h0000_0002;
    localparam logic [31:0] FEATURE_ID_C = 32'h0000_0003;

    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_REG_RD  = 3'h1,
        OP_REG_WR  = 3'h2,
        OP_SYS_RD  = 3'h3,
        OP_SYS_WR  = 3'h4,
        OP_STAT_RD = 3'h5,
        OP_STAT_WR = 3'h6,
        OP_ID_RD   = 3'h7
    } op_type;

    typedef struct packed {
        logic        valid;
        logic [3:0]  cpNum;
        logic        priv;
        op_type      op;
        logic        dbl;
        logic [4:0]  idx;
        logic [63:0] data;
    } fp_req_type;

    typedef struct packed {
        logic        valid;
        logic        fault;
        logic [63:0] data;
    } fp_rsp_type;

    typedef struct packed {
        logic valid;
        logic invalidOp;
        logic divZero;
        logic overflow;
        logic underflow;
        logic inexact;
        logic inputDenormal;
    } fp_exc_type;

    typedef struct packed {
        logic       flushZero;
        logic       defaultNan;
        logic       altHalf;
        logic [1:0] roundMode;
        logic       stdConfig;
    } fp_mode_type;

endpackage

//--- logic/fp_register_state.sv
`timescale 1ns/1ps
module fp_register_state (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      clkEn,
    input  wire logic                      accWrEn,
    input  wire logic [3:0]                accWrData,
    input  fp_state_pkg::fp_req_type       req,
    input  fp_state_pkg::fp_exc_type       exc,
    output fp_state_pkg::fp_rsp_type       rsp,
    output logic [3:0]                     accessCtrl,
    output logic [31:0]                    statusCtrl,
    output fp_state_pkg::fp_mode_type      mode
);

    // ==========================================================
    // State
    logic [31:0]               singleRegs [32];
    logic [3:0]                acc_r;
    logic [3:0]                acc_nxt;
    logic [31:0]               stat_r;
    logic [31:0]               stat_nxt;
    fp_state_pkg::fp_rsp_type  rsp_r;
    fp_state_pkg::fp_rsp_type  rsp_nxt;
    fp_state_pkg::fp_mode_type mode_r;
    fp_state_pkg::fp_mode_type mode_nxt;
    logic                      weLo;
    logic                      weHi;
    logic [4:0]                addrLo;
    logic [4:0]                addrHi;
    logic [31:0]               dataLo;
    logic [31:0]               dataHi;
    logic [1:0]                primary;
    logic [1:0]                secondaryEff;
    logic [1:0]                field;
    logic                      cpOk;
    logic                      granted;
    logic [31:0]               excBits;

    // ==========================================================
    // Access gating
    always_comb
    begin
        primary = acc_r[1:0];
        // A mismatched secondary field is unreliable, so it tracks the primary.
        secondaryEff = (acc_r[3:2] == primary) ? acc_r[3:2] : primary;
        cpOk = (req.cpNum == fp_state_pkg::CP_NUM_PRIMARY)
            || (req.cpNum == fp_state_pkg::CP_NUM_SECONDARY);
        field = (req.cpNum == fp_state_pkg::CP_NUM_SECONDARY) ? secondaryEff : primary;
        granted = (field == fp_state_pkg::ACC_FULL)
               || ((field == fp_state_pkg::ACC_PRIV) && req.priv);
    end

    // ==========================================================
    // Register, status and response next values
    always_comb
    begin
        acc_nxt = acc_r;
        stat_nxt = stat_r;
        rsp_nxt = '0;
        weLo = 1'b0;
        weHi = 1'b0;
        addrLo = req.dbl ? {req.idx[3:0], 1'b0} : req.idx;
        addrHi = {req.idx[3:0], 1'b1};
        dataLo = req.data[31:0];
        dataHi = req.data[63:32];
        excBits = '0;
        if (accWrEn)
        begin
            acc_nxt = accWrData;
        end
        if (req.valid && (req.op != fp_state_pkg::OP_NONE))
        begin
            rsp_nxt.valid = 1'b1;
            if (!(cpOk && granted))
            begin
                rsp_nxt.fault = 1'b1;
            end
            else
            begin
                case (req.op)
                    fp_state_pkg::OP_REG_RD:
                    begin
                        if (req.dbl)
                        begin
                            rsp_nxt.data = {singleRegs[addrHi], singleRegs[addrLo]};
                        end
                        else
                        begin
                            rsp_nxt.data = {32'h0000_0000, singleRegs[addrLo]};
                        end
                    end
                    fp_state_pkg::OP_REG_WR:
                    begin
                        // A single write leaves the other half of its double untouched.
                        weLo = 1'b1;
                        weHi = req.dbl;
                    end
                    fp_state_pkg::OP_SYS_RD:
                    begin
                        // Reserved locations read as zero.
                        if (req.idx[3:0] == fp_state_pkg::FLAGS_LOC)
                        begin
                            rsp_nxt.data[3:0] = stat_r[fp_state_pkg::POS_FLAGS +: 4];
                        end
                    end
                    fp_state_pkg::OP_SYS_WR:
                    begin
                        // Reserved locations ignore writes.
                        if (req.idx[3:0] == fp_state_pkg::FLAGS_LOC)
                        begin
                            stat_nxt[fp_state_pkg::POS_FLAGS +: 4] = req.data[3:0];
                        end
                    end
                    fp_state_pkg::OP_STAT_RD:
                    begin
                        rsp_nxt.data = {32'h0000_0000, stat_r};
                    end
                    fp_state_pkg::OP_STAT_WR:
                    begin
                        // Writable fields include flush and default NaN enables.
                        stat_nxt = req.data[31:0]
                                 & fp_state_pkg::STATUS_WR_MASK;
                    end
                    fp_state_pkg::OP_ID_RD:
                    begin
                        case (req.idx[1:0])
                            2'h0:
                            begin
                                rsp_nxt.data[31:0] = fp_state_pkg::FEATURE_ID_A;
                            end
                            2'h1:
                            begin
                                rsp_nxt.data[31:0] = fp_state_pkg::FEATURE_ID_B;
                            end
                            2'h2:
                            begin
                                rsp_nxt.data[31:0] = fp_state_pkg::FEATURE_ID_C;
                            end
                            default: rsp_nxt.data = '0;
                        endcase
                    end
                    default:
                    begin
                        rsp_nxt.fault = 1'b0;
                    end
                endcase
            end
        end
        // Exception flags are applied last so a same-cycle write cannot lose them.
        if (exc.valid)
        begin
            excBits[fp_state_pkg::POS_IOC] = exc.invalidOp;
            excBits[fp_state_pkg::POS_DZC] = exc.divZero;
            excBits[fp_state_pkg::POS_OFC] = exc.overflow;
            excBits[fp_state_pkg::POS_UFC] = exc.underflow;
            excBits[fp_state_pkg::POS_IXC] = exc.inexact;
            excBits[fp_state_pkg::POS_IDC] = exc.inputDenormal;
        end
        stat_nxt = stat_nxt | excBits;
    end

    // ==========================================================
    // Mode decode
    always_comb
    begin
        // Decoding the next status word keeps mode in step with statusCtrl.
        mode_nxt.flushZero = stat_nxt[fp_state_pkg::POS_FZ];
        mode_nxt.defaultNan = stat_nxt[fp_state_pkg::POS_DN];
        // Half-precision decoding and the stdConfig decode both look at this select.
        mode_nxt.altHalf = stat_nxt[fp_state_pkg::POS_AHP];
        mode_nxt.roundMode = stat_nxt[fp_state_pkg::POS_RMODE +: 2];
        mode_nxt.stdConfig = stat_nxt[fp_state_pkg::POS_FZ] && stat_nxt[fp_state_pkg::POS_DN]
                          && (stat_nxt[fp_state_pkg::POS_RMODE +: 2]
                              == fp_state_pkg::RMODE_NEAREST)
                          && !stat_nxt[fp_state_pkg::POS_AHP];
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_r <= fp_state_pkg::ACC_RESET;
            stat_r <= fp_state_pkg::STATUS_RESET;
            rsp_r <= '0;
            mode_r <= '0;
        end
        else if (clkEn)
        begin
            acc_r <= acc_nxt;
            stat_r <= stat_nxt;
            rsp_r <= rsp_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ==========================================================
    // Extension register storage
    // No reset here: the contents are undefined after reset, which saves area.
    // Raw bit patterns are kept, so every number class and format passes through.
    always_ff @(posedge clk)
    begin
        if (clkEn)
        begin
            if (weLo)
            begin
                singleRegs[addrLo] <= dataLo;
            end
            if (weHi)
            begin
                singleRegs[addrHi] <= dataHi;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign rsp = rsp_r;
    assign accessCtrl = acc_r;
    assign statusCtrl = stat_r;
    assign mode = mode_r;

endmodule

//--- bench/fp_register_state_chk.sv
`timescale 1ns/1ps
module fp_register_state_chk (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 clkEn,
    input wire logic                 accWrEn,
    input wire logic [3:0]           accWrData,
    input fp_state_pkg::fp_req_type  req,
    input fp_state_pkg::fp_exc_type  exc,
    input fp_state_pkg::fp_rsp_type  rsp,
    input wire logic [3:0]           accessCtrl,
    input wire logic [31:0]          statusCtrl,
    input fp_state_pkg::fp_mode_type mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic take = clkEn && req.valid && req.op != fp_state_pkg::OP_NONE;
    wire logic cpOk = req.cpNum inside {fp_state_pkg::CP_NUM_PRIMARY,
                                        fp_state_pkg::CP_NUM_SECONDARY};

    // ==========================================================
    // Checks
    property p_answer; take |=> rsp.valid; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_foreign; take && !cpOk |=> rsp.fault; endproperty
    a_foreign: assert property (p_foreign) else $error("foreign unit not refused");
    property p_denied;
        take && req.cpNum == fp_state_pkg::CP_NUM_PRIMARY && accessCtrl[1:0] == 2'h0 |=> rsp.fault;
    endproperty
    a_denied: assert property (p_denied) else $error("denied access not refused");
    property p_grant; clkEn && accWrEn |=> accessCtrl == $past(accWrData); endproperty
    a_grant: assert property (p_grant) else $error("access field not taken");
    property p_sticky; clkEn && exc.valid && exc.overflow |=> statusCtrl[2]; endproperty
    a_sticky: assert property (p_sticky) else $error("overflow not recorded");
    property p_flush; mode.flushZero == statusCtrl[24]; endproperty
    a_flush: assert property (p_flush) else $error("flush mode mismatch");
    property p_dnan; mode.defaultNan == statusCtrl[25]; endproperty
    a_dnan: assert property (p_dnan) else $error("default nan mismatch");
    property p_std;
        mode.stdConfig == (mode.flushZero && mode.defaultNan && !mode.altHalf
                           && mode.roundMode == 2'h0);
    endproperty
    a_std: assert property (p_std) else $error("standard config wrong");
    property p_stwr;
        take && cpOk && req.op == fp_state_pkg::OP_STAT_WR && accessCtrl == 4'hF && !exc.valid
        |=> statusCtrl == (fp_state_pkg::STATUS_WR_MASK & $past(req.data[31:0]));
    endproperty
    a_stwr: assert property (p_stwr) else $error("status write wrong");
    c_fault: cover property (rsp.valid && rsp.fault);
    c_dbl: cover property (take && req.dbl);
    c_exc: cover property (clkEn && exc.valid);
endmodule

bind fp_register_state fp_register_state_chk chk_u (.clk, .rst_n, .clkEn, .accWrEn, .accWrData,
    .req, .exc, .rsp, .accessCtrl, .statusCtrl, .mode);

//--- bench/fp_core_model.sv
`timescale 1ns/1ps
module fp_core_model (
    input  fp_state_pkg::fp_req_type cmd,
    output fp_state_pkg::fp_req_type req
);
    // ==========================================================
    // Issue path
    // A reserved system location is never issued; it becomes an idle slot instead.
    wire logic sysOp = cmd.op inside {fp_state_pkg::OP_SYS_RD, fp_state_pkg::OP_SYS_WR};
    assign req = (sysOp && cmd.idx[3:0] != fp_state_pkg::FLAGS_LOC) ? '0 : cmd;
endmodule

//--- bench/fp_register_state_test.sv
`timescale 1ns/1ps
module fp_register_state_test;
    localparam logic [3:0] CPP = fp_state_pkg::CP_NUM_PRIMARY;
    localparam logic [3:0] CPS = fp_state_pkg::CP_NUM_SECONDARY;
    logic                      clk;
    logic                      rst_n;
    logic                      clkEn;
    logic                      accWrEn;
    logic [3:0]                accWrData;
    fp_state_pkg::fp_req_type  cmd;
    fp_state_pkg::fp_req_type  req;
    fp_state_pkg::fp_exc_type  exc;
    fp_state_pkg::fp_rsp_type  rsp;
    logic [3:0]                accessCtrl;
    logic [31:0]               statusCtrl;
    fp_state_pkg::fp_mode_type mode;
    int                        errors = 0;
    int                        n_checks = 0;

    fp_core_model core_u (.cmd, .req);
    fp_register_state dut_u (.clk, .rst_n, .clkEn, .accWrEn, .accWrData, .req, .exc, .rsp,
        .accessCtrl, .statusCtrl, .mode);

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // The answer stands for the cycle after the taking edge, so it is read at the next fall.
    task automatic issue(input logic [3:0] cp, input fp_state_pkg::op_type op,
                         input logic [4:0] idx, input logic [63:0] d,
                         input logic dbl = 0, input logic pv = 1);
        @(negedge clk);
        cmd = '{1'b1, cp, pv, op, dbl, idx, d};
        @(negedge clk);
        cmd = '0;
    endtask

    task automatic grant(input logic [3:0] v);
        @(negedge clk);
        accWrEn = 1;
        accWrData = v;
        @(negedge clk);
        accWrEn = 0;
        chk(accessCtrl, v, "access field");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_access;
        chk({accessCtrl, statusCtrl, mode}, 0, "reset state");
        issue(CPP, fp_state_pkg::OP_REG_WR, 0, 1);
        chk({rsp.valid, rsp.fault}, 2'b11, "denied unit");
        grant(4'h1);
        issue(CPP, fp_state_pkg::OP_REG_WR, 0, 1, 0, 0);
        chk({rsp.valid, rsp.fault}, 2'b11, "unprivileged");
        issue(CPS, fp_state_pkg::OP_REG_WR, 0, 1);
        chk({rsp.valid, rsp.fault}, 2'b10, "secondary follows");
        grant(4'hF);
        issue(4'h9, fp_state_pkg::OP_REG_RD, 0, 0);
        chk({rsp.valid, rsp.fault}, 2'b11, "foreign unit");
        $display("test access done");
    endtask

    task automatic t_alias;
        issue(CPP, fp_state_pkg::OP_REG_WR, 5'h03, 64'h89AB_CDEF_0123_4567, 1);
        issue(CPS, fp_state_pkg::OP_REG_RD, 5'h07, 0);
        chk(rsp.data, 64'h0000_0000_89AB_CDEF, "odd single");
        issue(CPP, fp_state_pkg::OP_REG_RD, 5'h06, 0);
        chk(rsp.data, 64'h0000_0000_0123_4567, "even single");
        issue(CPP, fp_state_pkg::OP_REG_WR, 5'h1F, 64'h0000_0000_5555_AAAA);
        issue(CPP, fp_state_pkg::OP_REG_RD, 5'h0F, 0, 1);
        chk(rsp.data[63:32], 32'h5555_AAAA, "last double");
        $display("test alias done");
    endtask

    task automatic t_status;
        issue(CPP, fp_state_pkg::OP_STAT_WR, 0, 64'h0000_0000_FFFF_FFFF);
        chk(statusCtrl, 32'hF7C0_009F, "status mask");
        chk(mode, 6'b11_1110, "all modes");
        issue(CPP, fp_state_pkg::OP_STAT_RD, 0, 0);
        chk(rsp.data, 64'h0000_0000_F7C0_009F, "status read");
        issue(CPP, fp_state_pkg::OP_STAT_WR, 0, 64'h0000_0000_0300_0000);
        chk(mode, 6'b11_0001, "standard config");
        issue(CPP, fp_state_pkg::OP_SYS_WR, 5'h01, 64'h0000_0000_0000_000A);
        issue(CPS, fp_state_pkg::OP_SYS_RD, 5'h01, 0);
        chk(rsp.data, 64'h0000_0000_0000_000A, "flags read");
        chk(statusCtrl[31:28], 4'hA, "flags field");
        $display("test status done");
    endtask

    task automatic t_exc;
        logic [31:0] ids[4];
        ids = '{fp_state_pkg::FEATURE_ID_A, fp_state_pkg::FEATURE_ID_B,
                fp_state_pkg::FEATURE_ID_C, 32'h0000_0000};
        issue(CPP, fp_state_pkg::OP_STAT_WR, 0, 0);
        clkEn = 0;
        exc = 7'b101_1001;
        @(negedge clk);
        chk(statusCtrl, 0, "frozen");
        clkEn = 1;
        @(negedge clk);
        exc = '0;
        chk(statusCtrl, 32'h0000_0086, "sticky bits");
        for (int i = 0; i < 4; i++)
        begin
            issue(CPP, fp_state_pkg::OP_ID_RD, 5'(i), 0);
            chk(rsp.data, {32'h0000_0000, ids[i]}, "feature id");
        end
        // An exception in the same cycle as a clearing status write must survive it.
        @(negedge clk);
        cmd = '{1'b1, CPP, 1'b1, fp_state_pkg::OP_STAT_WR, 1'b0, 5'h00, 64'h0000_0000_0000_0000};
        exc = 7'b110_0000;
        @(negedge clk);
        cmd = '0;
        exc = '0;
        chk(statusCtrl, 32'h0000_0001, "set beats clear");
        $display("test exceptions done");
    endtask

    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        {rst_n, accWrEn, accWrData, cmd, exc} = '0;
        clkEn = 1;
        repeat (5) @(negedge clk);
        rst_n = 1;
        t_access;
        t_alias;
        t_status;
        t_exc;
        stop_test;
    end

    // The tests need well under 200 cycles; 5000 cycles means a hang.
    initial
    begin
        #100000;
        errors++;
        stop_test;
    end
endmodule
